/* File: rtcs_top.v */
`include "rtcs_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module rtcs_top #(
  parameter LINK_KIND = `RTCS_LINK_I2C,
  parameter XTAL_DIV = `RTCS_XTAL_DIV,
  parameter OSC_CYC = `RTCS_OSC_CYC
) (
  input wire clk_sys,
  input wire reset,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output reg sda_oe,
  input wire cs_n,
  input wire sck,
  input wire si,
  output wire so_out,
  output wire so_oe,
  input wire sio_in,
  output wire shared_serial_data_out,
  output wire shared_serial_data_oe,
  input wire low_voltage_warn,
  input wire low_voltage_min,
  output wire ready
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  localparam IS_I2C = (LINK_KIND == `RTCS_LINK_I2C);
  localparam IS_LSB = (LINK_KIND == `RTCS_LINK_3W);
  wire [7:0] pin_raw = {low_voltage_warn, low_voltage_min, sio_in, si, sck, cs_n, sda_in, scl_in};
  reg [7:0] s1_q, s2_q, s3_q;
  // idle pin levels, so no false edge or select after reset
  localparam [7:0] SYNC_IDLE = 8'h3f;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : sync
      always @(posedge clk_sys) begin
        if (reset) begin
          s1_q[g] <= SYNC_IDLE[g];
          s2_q[g] <= SYNC_IDLE[g];
          s3_q[g] <= SYNC_IDLE[g];
        end else begin
          s1_q[g] <= pin_raw[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
        end
      end
    end
  endgenerate

  // ****************************************
  // power-up sequence
  // ****************************************
  localparam I_CFG = 3'd0, I_OSC = 3'd1, I_VCHK = 3'd2, I_READ = 3'd3, I_RUN = 3'd4;
  reg [2:0] init_q;
  reg [15:0] icnt_q;
  localparam integer CFG_LAST = `RTCS_CFG_CYC - 1;
  localparam integer OSC_LAST = OSC_CYC - 1;
  always @(posedge clk_sys) begin
    if (reset) begin
      init_q <= I_CFG;
      icnt_q <= 16'h0000;
    end else begin
      icnt_q <= icnt_q + 16'h0001;
      case (init_q)
        I_CFG: if (icnt_q == CFG_LAST[15:0]) begin
          init_q <= I_OSC;
          icnt_q <= 16'h0000;
        end
        I_OSC: if (icnt_q == OSC_LAST[15:0]) init_q <= I_VCHK;
        I_VCHK: if (!s2_q[6]) init_q <= I_READ;
        I_READ: init_q <= I_RUN;
        I_RUN: icnt_q <= 16'h0000;
        default: init_q <= I_CFG;
      endcase
    end
  end
  wire run = (init_q == I_RUN);
  assign ready = run;

  // ****************************************
  // link edges and transaction framing
  // ****************************************
  wire lclk = IS_I2C ? s2_q[0] : s2_q[3];
  wire lclk_d = IS_I2C ? s3_q[0] : s3_q[3];
  wire ldat = IS_I2C ? s2_q[1] : (IS_LSB ? s2_q[5] : s2_q[4]);
  wire rise = lclk & ~lclk_d;
  wire fall = ~lclk & lclk_d;
  wire cs_act = ~s2_q[2];
  wire i2c_start = s2_q[0] & s3_q[0] & s3_q[1] & ~s2_q[1];
  wire i2c_stop = s2_q[0] & s3_q[0] & ~s3_q[1] & s2_q[1];
  wire tstart = run & (IS_I2C ? i2c_start : (s3_q[2] & ~s2_q[2]));
  wire tstop = run & (IS_I2C ? i2c_stop : (~s3_q[2] & s2_q[2]));

  localparam ST_IDLE = 3'd0, ST_DEV = 3'd1, ST_HDR = 3'd2, ST_WR = 3'd3, ST_RD = 3'd4;
  reg [2:0] st_q, nxt_q, wr_page_q;
  reg [3:0] cnt_q;
  reg [7:0] sh_q, rd_sh_q, wd_q;
  reg [6:0] addr_q, wa_q;
  reg ack_q, busy_q, wr_any_q, snap_q, back_q, wr_q, out_q;
  reg [7:0] rd_byte;

  wire [7:0] byte_in = IS_LSB ? {ldat, sh_q[7:1]} : {sh_q[6:0], ldat};
  wire [6:0] addr_inc = {addr_q[6:3], addr_q[2:0] + 3'd1};
  wire [2:0] bidx = IS_LSB ? cnt_q[2:0] : (3'd7 - cnt_q[2:0]);
  wire [7:0] rsrc = (cnt_q == 4'd0) ? rd_byte : rd_sh_q;
  wire rbit = rsrc[bidx];
  wire dev_hit = (byte_in[7:1] == `RTCS_I2C_ADDR);

  always @(posedge clk_sys) begin
    if (reset) begin
      st_q <= ST_IDLE;
      nxt_q <= ST_IDLE;
      wr_page_q <= 3'd0;
      cnt_q <= 4'd0;
      sh_q <= 8'h00;
      rd_sh_q <= 8'h00;
      wd_q <= 8'h00;
      addr_q <= 7'h00;
      wa_q <= 7'h00;
      ack_q <= 1'b0;
      busy_q <= 1'b0;
      wr_any_q <= 1'b0;
      snap_q <= 1'b0;
      back_q <= 1'b0;
      wr_q <= 1'b0;
      out_q <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      snap_q <= 1'b0;
      back_q <= 1'b0;
      wr_q <= 1'b0;
      if (tstart) begin
        st_q <= IS_I2C ? ST_DEV : ST_HDR;
        cnt_q <= 4'd0;
        ack_q <= 1'b0;
        sda_oe <= 1'b0;
        out_q <= 1'b0;
        if (!busy_q) begin
          busy_q <= 1'b1;
          snap_q <= 1'b1;
          wr_any_q <= 1'b0;
        end
      end else if (tstop) begin
        st_q <= ST_IDLE;
        busy_q <= 1'b0;
        ack_q <= 1'b0;
        sda_oe <= 1'b0;
        out_q <= 1'b0;
        back_q <= busy_q & wr_any_q;
      end else if (rise && st_q != ST_IDLE) begin
        if (cnt_q == 4'd8) begin
          cnt_q <= 4'd0;
          st_q <= nxt_q;
          if (st_q == ST_RD && !ldat) addr_q <= addr_inc;
        end else begin
          sh_q <= byte_in;
          cnt_q <= (cnt_q == 4'd7 && !IS_I2C) ? 4'd0 : cnt_q + 4'd1;
          if (cnt_q == 4'd7) begin
            case (st_q)
              ST_DEV: begin
                ack_q <= dev_hit;
                nxt_q <= dev_hit ? (byte_in[0] ? ST_RD : ST_HDR) : ST_IDLE;
              end
              ST_HDR: begin
                addr_q <= byte_in[6:0];
                ack_q <= 1'b1;
                nxt_q <= ST_WR;
                if (!IS_I2C) st_q <= byte_in[7] ? ST_RD : ST_WR;
              end
              ST_WR: begin
                wr_q <= 1'b1;
                wa_q <= addr_q;
                wd_q <= byte_in;
                addr_q <= addr_inc;
                ack_q <= 1'b1;
                if (!wr_any_q) begin
                  wr_any_q <= 1'b1;
                  wr_page_q <= addr_q[5:3];
                end
              end
              ST_RD: begin
                ack_q <= 1'b0;
                if (!IS_I2C) addr_q <= addr_inc;
              end
              default: ack_q <= 1'b0;
            endcase
          end
        end
      end else if (fall) begin
        if (IS_I2C)
          sda_oe <= (st_q == ST_RD) ? (cnt_q != 4'd8 && !rbit) : (cnt_q == 4'd8 && ack_q);
        else
          out_q <= (st_q == ST_RD) & rbit;
        if (cnt_q == 4'd0) rd_sh_q <= rd_byte;
      end
    end
  end

  assign sda_out = 1'b0;
  assign so_oe = (LINK_KIND == `RTCS_LINK_SPI) & cs_act;
  assign so_out = (LINK_KIND == `RTCS_LINK_SPI) & out_q;
  assign shared_serial_data_oe = IS_LSB & cs_act & (st_q == ST_RD);
  assign shared_serial_data_out = out_q;

  // ****************************************
  // time base
  // ****************************************
  reg [11:0] xd_q;
  reg [`RTCS_PRE_W-1:0] pre_q;
  reg half_q;
  localparam integer XD_LAST = XTAL_DIV - 1;
  wire xtal_en = (xd_q == XD_LAST[11:0]);
  wire back_watch = back_q & (wr_page_q == `RTCS_PG_WATCH);
  wire tick1 = xtal_en & (&pre_q);
  always @(posedge clk_sys) begin
    if (reset) begin
      xd_q <= 12'h000;
      pre_q <= {`RTCS_PRE_W{1'b0}};
      half_q <= 1'b0;
    end else begin
      xd_q <= xtal_en ? 12'h000 : xd_q + 12'h001;
      if (back_watch) pre_q <= {`RTCS_PRE_W{1'b0}};
      else if (xtal_en) pre_q <= pre_q + 1'b1;
      if (tick1) half_q <= ~half_q;
    end
  end

  // ****************************************
  // register storage and cache
  // ****************************************
  reg [7:0] mem_q [0:63];
  reg [7:0] cache_q [0:9];
  reg af_q, tf_q, vl1_q, vl2_q;
  reg [15:0] tcnt_q, reload_q;
  reg [7:0] temp_q;
  wire [55:0] wv;
  wire step_done;
  wire [7:0] onoff = mem_q[0];

  function loc_ok;
    input [6:0] a;
    begin
      case (a[5:3])
        `RTCS_PG_CTRL: loc_ok = (a[2:0] <= `RTCS_IDX_RSTCTRL);
        `RTCS_PG_WATCH, `RTCS_PG_ALARM: loc_ok = (a[2:0] != 3'd7);
        `RTCS_PG_TIMER, `RTCS_PG_EEDATA: loc_ok = (a[2:1] == 2'd0);
        `RTCS_PG_TEMP: loc_ok = (a[2:0] == 3'd0);
        `RTCS_PG_EECTRL: loc_ok = ~a[2];
        default: loc_ok = 1'b1;
      endcase
      loc_ok = loc_ok & ~a[6];
    end
  endfunction

  function [3:0] cidx;
    input [6:0] a;
    begin
      case (a[5:3])
        `RTCS_PG_WATCH: cidx = {1'b0, a[2:0]};
        `RTCS_PG_TIMER: cidx = 4'd7 + {3'd0, a[0]};
        default: cidx = 4'd9;
      endcase
    end
  endfunction

  always @* begin
    rd_byte = 8'h00;
    if (loc_ok(addr_q)) begin
      case (addr_q[5:3])
        `RTCS_PG_CTRL: case (addr_q[2:0])
          `RTCS_IDX_FLAGS: rd_byte = {6'd0, tf_q, af_q};
          `RTCS_IDX_STATUS: rd_byte = {4'd0, vl2_q, vl1_q, 2'd0};
          `RTCS_IDX_RSTCTRL: rd_byte = 8'h00;
          default: rd_byte = mem_q[addr_q[5:0]];
        endcase
        `RTCS_PG_WATCH, `RTCS_PG_TIMER, `RTCS_PG_TEMP: rd_byte = cache_q[cidx(addr_q)];
        default: rd_byte = mem_q[addr_q[5:0]];
      endcase
    end
  end

  // ****************************************
  // timer, flags and alarm match
  // ****************************************
  wire [1:0] rate = {onoff[`RTCS_B_TD1], onoff[`RTCS_B_TD0]};
  reg t_tick;
  always @* begin
    case (rate)
      2'b00: t_tick = xtal_en & (&pre_q[`RTCS_DIV_32HZ-1:0]);
      2'b10: t_tick = xtal_en & (&pre_q[`RTCS_DIV_8HZ-1:0]);
      2'b01: t_tick = tick1;
      default: t_tick = tick1 & half_q;
    endcase
  end
  wire back_timer = back_q & (wr_page_q == `RTCS_PG_TIMER);
  wire t_step = t_tick & onoff[`RTCS_B_TIMER_RUN_EN] & ~back_timer & (tcnt_q != 16'h0000);
  wire tf_set = t_step & (tcnt_q == 16'h0001);

  wire [6:0] a_en, a_fit;
  generate
    for (g = 0; g < 7; g = g + 1) begin : alarm
      assign a_en[g] = mem_q[`RTCS_ALARM_BASE + g][7];
      assign a_fit[g] = ~a_en[g] | (mem_q[`RTCS_ALARM_BASE + g][6:0] == wv[8*g +: 7]);
    end
  endgenerate
  wire af_set = step_done & (|a_en) & (&a_fit);

  wire wr_ok = wr_q & loc_ok(wa_q);
  wire wr_flags = wr_ok & (wa_q[5:0] == {`RTCS_PG_CTRL, `RTCS_IDX_FLAGS});
  wire wr_stat = wr_ok & (wa_q[5:0] == {`RTCS_PG_CTRL, `RTCS_IDX_STATUS});
  integer i;

  always @(posedge clk_sys) begin
    if (reset) begin
      for (i = 0; i < 64; i = i + 1)
        mem_q[i] <= 8'h00;
      mem_q[0] <= `RTCS_ONOFF_RST;
      for (i = 0; i < 10; i = i + 1)
        cache_q[i] <= 8'h00;
      af_q <= 1'b0;
      tf_q <= 1'b0;
      vl1_q <= 1'b0;
      vl2_q <= 1'b0;
      tcnt_q <= 16'h0000;
      reload_q <= 16'h0000;
      temp_q <= `RTCS_TEMP_RST;
    end else begin
      af_q <= af_set | (af_q & ~(wr_flags & ~wd_q[`RTCS_B_AF]));
      tf_q <= tf_set | (tf_q & ~(wr_flags & ~wd_q[`RTCS_B_TF]));
      vl1_q <= s2_q[7] | (vl1_q & ~(wr_stat & ~wd_q[`RTCS_B_LOW_VOLTAGE_WARN]));
      vl2_q <= s2_q[6] | (vl2_q & ~(wr_stat & ~wd_q[`RTCS_B_LOW_VOLTAGE_MIN]));
      if (wr_ok) begin
        case (wa_q[5:3])
          `RTCS_PG_CTRL: if (wa_q[2:1] == 2'd0) mem_q[wa_q[5:0]] <= wd_q;
          `RTCS_PG_WATCH, `RTCS_PG_TIMER, `RTCS_PG_TEMP: cache_q[cidx(wa_q)] <= wd_q;
          default: mem_q[wa_q[5:0]] <= wd_q;
        endcase
      end
      if (snap_q) begin
        for (i = 0; i < 7; i = i + 1)
          cache_q[i] <= wv[8*i +: 8];
        cache_q[7] <= onoff[`RTCS_B_TIMER_RELOAD_MODE] ? reload_q[7:0] : tcnt_q[7:0];
        cache_q[8] <= onoff[`RTCS_B_TIMER_RELOAD_MODE] ? reload_q[15:8] : tcnt_q[15:8];
        cache_q[9] <= temp_q;
      end
      if (back_timer) begin
        tcnt_q <= {cache_q[8], cache_q[7]};
        reload_q <= {cache_q[8], cache_q[7]};
      end else if (t_step) begin
        if (tcnt_q == 16'h0001)
          tcnt_q <= onoff[`RTCS_B_TIMER_RELOAD_MODE] ? reload_q : 16'h0000;
        else
          tcnt_q <= tcnt_q - 16'h0001;
      end
      if (back_q && wr_page_q == `RTCS_PG_TEMP) temp_q <= cache_q[9];
    end
  end

  // ****************************************
  // calendar
  // ****************************************
  rtcs_watch u_watch (
    .clk_sys(clk_sys),
    .reset(reset),
    .run_en(run & onoff[`RTCS_B_WAON]),
    .sec_tick(tick1),
    .load_en(back_watch),
    .ld_sec(cache_q[0]),
    .ld_min(cache_q[1]),
    .ld_hour(cache_q[2]),
    .ld_date(cache_q[3]),
    .ld_wday(cache_q[4]),
    .ld_month(cache_q[5]),
    .ld_year(cache_q[6]),
    .sec_q(wv[7:0]),
    .min_q(wv[15:8]),
    .hour_q(wv[23:16]),
    .date_q(wv[31:24]),
    .wday_q(wv[39:32]),
    .month_q(wv[47:40]),
    .year_q(wv[55:48]),
    .step_done(step_done)
  );
endmodule
`default_nettype wire

/* File: rtcs_consts.vh */
`ifndef RTCS_CONSTS_VH
`define RTCS_CONSTS_VH
// ****************************************
// clocking and time base
// ****************************************
`define RTCS_CLK_HZ 100000000
`define RTCS_XTAL_HZ 32768
`define RTCS_XTAL_DIV (`RTCS_CLK_HZ / `RTCS_XTAL_HZ)
`define RTCS_PRE_W 15
`define RTCS_DIV_32HZ 10
`define RTCS_DIV_8HZ 12
`define RTCS_CFG_CYC 8
`define RTCS_OSC_START_NS 1000
`define RTCS_CLK_NS 10
`define RTCS_OSC_CYC ((`RTCS_OSC_START_NS + `RTCS_CLK_NS - 1) / `RTCS_CLK_NS)
// ****************************************
// link variants and addressing
// ****************************************
`define RTCS_LINK_I2C 0
`define RTCS_LINK_SPI 1
`define RTCS_LINK_3W 2
`define RTCS_I2C_ADDR 7'h56
`define RTCS_PG_CTRL 3'h0
`define RTCS_PG_WATCH 3'h1
`define RTCS_PG_ALARM 3'h2
`define RTCS_PG_TIMER 3'h3
`define RTCS_PG_TEMP 3'h4
`define RTCS_PG_EEDATA 3'h5
`define RTCS_PG_EECTRL 3'h6
`define RTCS_PG_RAM 3'h7
`define RTCS_ALARM_BASE 6'h10
// ****************************************
// control page fields and reset values
// ****************************************
`define RTCS_IDX_ONOFF 3'h0
`define RTCS_IDX_IRQCTRL 3'h1
`define RTCS_IDX_FLAGS 3'h2
`define RTCS_IDX_STATUS 3'h3
`define RTCS_IDX_RSTCTRL 3'h4
`define RTCS_ONOFF_RST 8'h99
`define RTCS_B_TD1 6
`define RTCS_B_TD0 5
`define RTCS_B_TIMER_RELOAD_MODE 2
`define RTCS_B_TIMER_RUN_EN 1
`define RTCS_B_WAON 0
`define RTCS_B_TF 1
`define RTCS_B_AF 0
`define RTCS_B_LOW_VOLTAGE_MIN 3
`define RTCS_B_LOW_VOLTAGE_WARN 2
`define RTCS_TEMP_RST 8'h00
`endif

/* File: rtcs_watch.v */
`timescale 1ns/1ns
`default_nettype none
module rtcs_watch (
  input wire clk_sys,
  input wire reset,
  input wire run_en,
  input wire sec_tick,
  input wire load_en,
  input wire [7:0] ld_sec,
  input wire [7:0] ld_min,
  input wire [7:0] ld_hour,
  input wire [7:0] ld_date,
  input wire [7:0] ld_wday,
  input wire [7:0] ld_month,
  input wire [7:0] ld_year,
  output reg [7:0] sec_q,
  output reg [7:0] min_q,
  output reg [7:0] hour_q,
  output reg [7:0] date_q,
  output reg [7:0] wday_q,
  output reg [7:0] month_q,
  output reg [7:0] year_q,
  output reg step_done
);
  // ****************************************
  // bcd helpers
  // ****************************************
  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9)
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      else
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  wire [1:0] leap_mod = {year_q[4], 1'b0} + year_q[1:0];
  wire leap = (leap_mod == 2'h0);
  reg [7:0] last_day;

  always @* begin
    case (month_q)
      8'h02: last_day = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
      default: last_day = 8'h31;
    endcase
  end

  // ****************************************
  // calendar counting
  // ****************************************
  always @(posedge clk_sys) begin
    if (reset) begin
      sec_q <= 8'h00;
      min_q <= 8'h00;
      hour_q <= 8'h00;
      date_q <= 8'h01;
      wday_q <= 8'h01;
      month_q <= 8'h01;
      year_q <= 8'h00;
      step_done <= 1'b0;
    end else begin
      step_done <= 1'b0;
      if (load_en) begin
        sec_q <= ld_sec;
        min_q <= ld_min;
        hour_q <= ld_hour;
        date_q <= ld_date;
        wday_q <= ld_wday;
        month_q <= ld_month;
        year_q <= ld_year;
      end else if (run_en && sec_tick) begin
        step_done <= 1'b1;
        if (sec_q != 8'h59) begin
          sec_q <= bcd_inc(sec_q);
        end else begin
          sec_q <= 8'h00;
          if (min_q != 8'h59) begin
            min_q <= bcd_inc(min_q);
          end else begin
            min_q <= 8'h00;
            if (hour_q != 8'h23) begin
              hour_q <= bcd_inc(hour_q);
            end else begin
              hour_q <= 8'h00;
              wday_q <= (wday_q == 8'h07) ? 8'h01 : bcd_inc(wday_q);
              if (date_q != last_day) begin
                date_q <= bcd_inc(date_q);
              end else begin
                date_q <= 8'h01;
                if (month_q != 8'h12) begin
                  month_q <= bcd_inc(month_q);
                end else begin
                  month_q <= 8'h01;
                  year_q <= (year_q == 8'h79) ? 8'h00 : bcd_inc(year_q);
                end
              end
            end
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: rtcs_props.sv */
`timescale 1ns/1ns
`default_nettype none
module rtcs_props #(
  parameter LINK_KIND = 0
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so_out,
  input wire logic so_oe,
  input wire logic sda_oe,
  input wire logic shared_serial_data_oe,
  input wire logic low_voltage_min,
  input wire logic ready
);
  // ****************************
  // link phase tracking
  // ****************************
  logic sck_q;
  logic cs_q;
  logic rw_q;
  logic [3:0] rise_cnt_q;
  logic [3:0] age_q;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sck_q <= 1'b1;
      cs_q <= 1'b1;
      rw_q <= 1'b0;
      rise_cnt_q <= 4'h0;
      age_q <= 4'hf;
    end else begin
      sck_q <= sck;
      cs_q <= cs_n;
      if (cs_n) begin
        rise_cnt_q <= 4'h0;
      end else if (sck && !sck_q && rise_cnt_q != 4'hf) begin
        rise_cnt_q <= rise_cnt_q + 4'h1;
        if (rise_cnt_q == 4'h0) begin
          rw_q <= si;
        end
      end
      // cycles since a clock fall or a select change
      if ((!sck && sck_q) || (cs_n != cs_q)) begin
        age_q <= 4'h0;
      end else if (age_q != 4'hf) begin
        age_q <= age_q + 4'h1;
      end
    end
  end
  // ****************************
  // properties
  // ****************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  sequence s_config_wait;
    !ready [*8];
  endsequence
  a_power_up_order: assert property ($fell(reset) && !low_voltage_min |-> s_config_wait ##[1:400] ready)
    else $error("ready out of order after reset");
  a_ready_holds: assert property (ready |=> ready)
    else $error("ready dropped in normal operation");
  a_so_released: assert property (cs_n [*5] |-> !so_oe)
    else $error("serial output driven while deselected");
  a_so_driven_sel: assert property (!cs_n [*5] |-> so_oe || LINK_KIND != 1)
    else $error("serial output not driven while selected");
  a_two_wire_idle: assert property (LINK_KIND != 0 |-> !sda_oe)
    else $error("two-wire pin driven in other build");
  a_shared_line_idle: assert property (LINK_KIND != 2 |-> !shared_serial_data_oe)
    else $error("shared line driven in other build");
  a_write_out_low: assert property (!cs_n && !rw_q && rise_cnt_q >= 4'h9 |-> !so_out)
    else $error("serial output not low during write");
  a_change_on_fall: assert property (!cs_n && $changed(so_out) |-> age_q <= 4'h6)
    else $error("serial output changed away from a clock fall");
endmodule
bind rtcs_top rtcs_props #(.LINK_KIND(LINK_KIND)) u_rtcs_props (
  .clk_sys(clk_sys),
  .reset(reset),
  .cs_n(cs_n),
  .sck(sck),
  .si(si),
  .so_out(so_out),
  .so_oe(so_oe),
  .sda_oe(sda_oe),
  .shared_serial_data_oe(shared_serial_data_oe),
  .low_voltage_min(low_voltage_min),
  .ready(ready)
);
`default_nettype wire

/* File: rtcs_spi_master.sv */
`timescale 1ns/1ns
`default_nettype none
module rtcs_spi_master (
  input wire logic clk_sys,
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so_out
);
  // ****************************
  // four-wire bus master
  // ****************************
  initial begin
    cs_n = 1'b1;
    sck = 1'b1;
    si = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic xbyte(input logic [7:0] w, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      sck <= 1'b0;
      si <= w[i];
      tick(8);
      r[i] = so_out;
      sck <= 1'b1;
      tick(8);
    end
  endtask
  task automatic open_tx(input logic rd, input logic [6:0] a);
    logic [7:0] d;
    cs_n <= 1'b0;
    tick(8);
    xbyte({rd, a}, d);
  endtask
  task automatic close_tx();
    tick(8);
    cs_n <= 1'b1;
    si <= ~si;
    tick(16);
  endtask
endmodule
`default_nettype wire

/* File: rtcs_top_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module rtcs_top_bench;
  // ****************************
  // clock, reset and design
  // ****************************
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic low_voltage_min = 1'b0;
  logic low_voltage_warn = 1'b0;
  wire cs_n, sck, si, so_out, ready;
  wire so_oe;
  wire so_line;
  // released output shows the inverse, so a lost drive is seen
  assign so_line = so_oe ? so_out : ~so_out;
  int fails = 0;
  int n_tests = 0;
  always #5 clk_sys = ~clk_sys;
  rtcs_top #(.LINK_KIND(1), .XTAL_DIV(2), .OSC_CYC(1)) u_rtcs_top (
    .clk_sys(clk_sys),
    .reset(reset),
    .scl_in(1'b1),
    .sda_in(1'b1),
    .sda_out(),
    .sda_oe(),
    .cs_n(cs_n),
    .sck(sck),
    .si(si),
    .so_out(so_out),
    .so_oe(so_oe),
    .sio_in(si),
    .shared_serial_data_out(),
    .shared_serial_data_oe(),
    .low_voltage_warn(low_voltage_warn),
    .low_voltage_min(low_voltage_min),
    .ready(ready)
  );
  rtcs_spi_master u_rtcs_spi_master (
    .clk_sys(clk_sys),
    .cs_n(cs_n),
    .sck(sck),
    .si(si),
    .so_out(so_line)
  );
  // ****************************
  // shared tasks
  // ****************************
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d[$]);
    logic [7:0] r;
    u_rtcs_spi_master.open_tx(1'b0, a);
    foreach (d[i]) u_rtcs_spi_master.xbyte(d[i], r);
    u_rtcs_spi_master.close_tx();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e[$]);
    logic [7:0] r;
    u_rtcs_spi_master.open_tx(1'b1, a);
    foreach (e[i]) begin
      // input pattern must not disturb a read
      u_rtcs_spi_master.xbyte(8'ha5, r);
      chk(r, e[i]);
    end
    u_rtcs_spi_master.close_tx();
  endtask
  // ****************************
  // scenarios
  // ****************************
  task automatic power_up();
    int i;
    for (i = 0; i < 500 && ready !== 1'b1; i++) begin
      @(posedge clk_sys);
    end
    n_tests++;
    if (ready !== 1'b1) begin
      fails++;
      $display("BAD %0t ready never rose", $time);
      close_out();
    end
    chk({7'd0, so_oe}, 8'h00);
    rd(7'h00, {8'h99});
  endtask
  task automatic volt_status();
    low_voltage_warn <= 1'b1;
    low_voltage_min <= 1'b1;
    wait_cyc(4);
    low_voltage_warn <= 1'b0;
    low_voltage_min <= 1'b0;
    wait_cyc(4);
    rd(7'h03, {8'h0c});
    wr(7'h03, {8'h00});
    rd(7'h03, {8'h00});
  endtask
  task automatic ram_wrap();
    wr(7'h3e, {8'ha1, 8'hb2, 8'hc3});
    rd(7'h3e, {8'ha1, 8'hb2, 8'hc3});
    rd(7'h38, {8'hc3});
  endtask
  task automatic unused_place();
    wr(7'h41, {8'h5a});
    rd(7'h41, {8'h00});
  endtask
  task automatic watch_timer();
    wr(7'h10, {8'h80});
    wr(7'h18, {8'h01, 8'h00});
    wr(7'h08, {8'h59, 8'h59, 8'h23});
    wr(7'h00, {8'hdb});
    wait_cyc(3000);
    rd(7'h02, {8'h00});
    wait_cyc(6000);
    rd(7'h02, {8'h02});
    rd(7'h18, {8'h00, 8'h00});
    wr(7'h02, {8'h00});
    wr(7'h00, {8'h99});
    wait_cyc(44000);
    rd(7'h08, {8'h59, 8'h59, 8'h23});
    wait_cyc(12000);
    rd(7'h08, {8'h00, 8'h00, 8'h00, 8'h02, 8'h02});
    rd(7'h02, {8'h01});
  endtask
  task automatic timer_reload();
    wr(7'h18, {8'h05, 8'h00});
    wr(7'h00, {8'h9f});
    wait_cyc(5000);
    rd(7'h18, {8'h05, 8'h00});
    wait_cyc(6000);
    rd(7'h02, {8'h03});
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    power_up();
    ram_wrap();
    unused_place();
    volt_status();
    watch_timer();
    timer_reload();
    close_out();
  end
endmodule
`default_nettype wire
